// [src/pmrb_config_bank.sv]
// Configuration register bank of the power manager with the pin and rail controls it steers.
//
// Summary of operation
// - Bit 7 sets feedback output three polarity.
// - Bit 6 sets feedback two polarity, drive.
// - Forced-reset bit holds system reset asserted.
// - Bit 4 selects continuous high-speed interface.
// - Bit 3 selects fast-mode-plus interface timing.
// - Bit 2 keeps system-enable on second read.
// - Bit 1 defers interrupt until active mode.
// - Switch and buck autostart bits force enable at power-up.
// - LDO autostart bits force enable at power-up.
// - LDO bypass bits select bypass mode.
// - Memory/IO join set ignores IO buck controls.
// - Dual-phase set ignores core buck two controls.
// - Full-current bits double pass device, limit.
// - Sense route picks feedback two or pin.
// - Bit 1 makes LDO eight a motor driver.
// - Bit 0 picks 2 or 1 MHz PWM.
`timescale 1ns/1ps
`default_nettype none
`include "pmrb_params.svh"

module pmrb_config_bank #(
  parameter int CLK_HZ = `PMRB_CLK_HZ
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the two-wire interface, pages 2 and 3.
  input wire pmrb_pkg::pmrb_addr_t reg_addr,
  input wire logic reg_wr,
  input wire pmrb_pkg::pmrb_byte_t reg_wdata,
  input wire logic reg_rd,
  output pmrb_pkg::pmrb_byte_t reg_rdata,
  // Feedback outputs and system reset.
  input wire logic fb3_level,
  input wire logic fb2_level,
  input wire logic fb2_is_power_good,
  input wire logic reset_request,
  output logic feedback_output_three,
  output logic feedback_output_two_o,
  output logic feedback_output_two_oe,
  output logic system_reset_out_n,
  // Host interface mode.
  output logic continuous_highspeed_select,
  output logic fast_plus_timing_select,
  output logic input_supply_select,
  // Reload of the system-enable control.
  input wire logic otp_first_read,
  input wire logic otp_second_read,
  input wire logic otp_system_en,
  output logic system_en,
  // Interrupt signalling.
  input wire logic event_pending,
  input wire logic in_active_mode,
  output logic interrupt_out_n,
  // Start-up selection; LDO order is 3, 7, 8, 9, 11.
  input wire logic powering_up,
  input wire logic [7:0] rail_own_conf,
  input wire logic [4:0] ldo_own_conf,
  output logic [7:0] rail_start_en,
  output logic [4:0] ldo_start_en,
  // LDO bypass, order 3, 7, 8, 11, and LDO eight function.
  output logic [3:0] ldo_bypass,
  output logic ldo_eight_function,
  // Buck controls and merging.
  input wire logic [7:0] io_buck_ctrl,
  input wire logic [7:0] core_buck_two_ctrl,
  input wire logic remote_sense_en,
  output logic [7:0] io_buck_ctrl_eff,
  output logic [7:0] core_buck_two_ctrl_eff,
  output logic mem_io_buck_join,
  output logic core_buck_dual_phase,
  output logic core_buck_one_full_current,
  output logic core_buck_two_full_current,
  output logic processor_buck_full_current,
  output logic sense_on_feedback_two,
  output logic sense_on_core_switch_pin,
  // Vibration driver PWM timing.
  output logic pwm_clk_tick,
  output logic pwm_period_tick
);
  import pmrb_pkg::*;

  // Divider ratios for the two PWM clocks.
  localparam int DIV_FAST = CLK_HZ / `PMRB_PWM_FAST_HZ;
  localparam int DIV_SLOW = CLK_HZ / `PMRB_PWM_SLOW_HZ;
  localparam logic [5:0] DIV_FAST_M1 = 6'(DIV_FAST - 1);
  localparam logic [5:0] DIV_SLOW_M1 = 6'(DIV_SLOW - 1);
  localparam logic [5:0] STEP_LAST = 6'(`PMRB_PWM_STEPS - 1);

  // The divider counter is six bits wide, so the slow ratio must fit it.
  if (DIV_SLOW < 2 || DIV_SLOW > 64 || CLK_HZ % `PMRB_PWM_SLOW_HZ != 0
      || CLK_HZ % `PMRB_PWM_FAST_HZ != 0) begin : g_clk_check
    $error("CLK_HZ cannot produce the PWM clocks");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  pmrb_byte_t pin_and_interface_options_q; // Pins and host interface.
  pmrb_byte_t buck_switch_startup_select_q; // Switch and buck autostart.
  pmrb_byte_t ldo_bypass_and_startup_q; // LDO bypass and autostart.
  pmrb_byte_t ldo_startup_select_q; // LDO autostart.
  pmrb_byte_t mem_io_buck_join_and_drive_q; // Merging, drive, PWM clock.
  pmrb_byte_t reg_rdata_q; // Read data register.

  // All eight bits are stored, so reserved bits return what was written.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_and_interface_options_q <= `PMRB_REG_RESET;
      buck_switch_startup_select_q <= `PMRB_REG_RESET;
      ldo_bypass_and_startup_q <= `PMRB_REG_RESET;
      ldo_startup_select_q <= `PMRB_REG_RESET;
      mem_io_buck_join_and_drive_q <= `PMRB_REG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `PMRB_ADDR_PIN_OPT: pin_and_interface_options_q <= reg_wdata;
        `PMRB_ADDR_BUCK_START: buck_switch_startup_select_q <= reg_wdata;
        `PMRB_ADDR_LDO_BYP: ldo_bypass_and_startup_q <= reg_wdata;
        `PMRB_ADDR_LDO_START: ldo_startup_select_q <= reg_wdata;
        `PMRB_ADDR_MERGE: mem_io_buck_join_and_drive_q <= reg_wdata;
        default: begin
          // Other addresses belong to other banks and are ignored here.
        end
      endcase
    end
  end

  // Read data is captured on the strobe edge; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `PMRB_REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        `PMRB_ADDR_PIN_OPT: reg_rdata_q <= pin_and_interface_options_q;
        `PMRB_ADDR_BUCK_START: reg_rdata_q <= buck_switch_startup_select_q;
        `PMRB_ADDR_LDO_BYP: reg_rdata_q <= ldo_bypass_and_startup_q;
        `PMRB_ADDR_LDO_START: reg_rdata_q <= ldo_startup_select_q;
        `PMRB_ADDR_MERGE: reg_rdata_q <= mem_io_buck_join_and_drive_q;
        default: reg_rdata_q <= `PMRB_REG_RESET;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Field aliases.

  logic fb2_pol; // Feedback two polarity and drive.
  logic dual_phase; // Core bucks merged.
  logic route_to_pin; // Merged sense on the core-switch pin.
  logic pwm_slow; // PWM clock is 1 MHz.
  logic fb2_is_sense; // Feedback two carries the sense rail.
  assign fb2_pol = pin_and_interface_options_q[`PMRB_FB2_POL_BIT];
  assign dual_phase = mem_io_buck_join_and_drive_q[`PMRB_DUAL_PHASE_BIT];
  assign route_to_pin = mem_io_buck_join_and_drive_q[`PMRB_SENSE_ROUTE_BIT];
  assign pwm_slow = mem_io_buck_join_and_drive_q[`PMRB_PWM_CLK_BIT] == PMRB_PWM_1MHZ;
  // With routing to feedback two, the pin gives up its normal function.
  assign fb2_is_sense = dual_phase && remote_sense_en && !route_to_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  logic fb3_q; // Feedback three pin level.
  logic fb2_o_q; // Feedback two driven level.
  logic fb2_oe_q; // Feedback two drive enable.
  logic sys_rst_n_q; // System reset pin.

  // Feedback pins are registered so the pads never see decode glitches.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb3_q <= 1'b1;
      fb2_o_q <= 1'b1;
      fb2_oe_q <= 1'b0;
    end else begin
      // Zero drives active low, one drives the signal unchanged.
      fb3_q <= pin_opt_bit(`PMRB_FB3_POL_BIT) ? fb3_level : !fb3_level;
      if (fb2_is_sense) begin
        // The pad is released to the sense path.
        fb2_o_q <= 1'b0;
        fb2_oe_q <= 1'b0;
      end else if (fb2_pol && fb2_is_power_good) begin
        // Open drain, active high: pull low only while power is not good.
        fb2_o_q <= 1'b0;
        fb2_oe_q <= !fb2_level;
      end else begin
        // Push-pull, active low for zero and active high for one.
        fb2_o_q <= fb2_pol ? fb2_level : !fb2_level;
        fb2_oe_q <= 1'b1;
      end
    end
  end

  // Reset pin is held low while the forced-reset bit is set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_n_q <= 1'b0;
    end else begin
      sys_rst_n_q <= !(pin_opt_bit(`PMRB_FORCE_RST_BIT) || reset_request);
    end
  end

  // Reads one bit of pin_and_interface_options.
  function automatic logic pin_opt_bit(input int idx);
    return pin_and_interface_options_q[idx];
  endfunction : pin_opt_bit

  assign feedback_output_three = fb3_q;
  assign feedback_output_two_o = fb2_o_q;
  assign feedback_output_two_oe = fb2_oe_q;
  assign system_reset_out_n = sys_rst_n_q;
  assign continuous_highspeed_select = pin_opt_bit(`PMRB_HSM_BIT);
  assign fast_plus_timing_select = pin_opt_bit(`PMRB_FMP_BIT);
  assign input_supply_select = pin_opt_bit(`PMRB_SUPPLY_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // System enable and interrupt.

  logic system_en_q; // System-enable control.
  logic irq_n_q; // Interrupt pin.

  // First read always loads; second read loads only when not held.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_en_q <= 1'b0;
    end else if (otp_first_read) begin
      system_en_q <= otp_system_en;
    end else if (otp_second_read && !pin_opt_bit(`PMRB_SYSEN_KEEP_BIT)) begin
      system_en_q <= otp_system_en;
    end
  end

  // Deferred events stay pending in the controller until active mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(event_pending && (!pin_opt_bit(`PMRB_IRQ_DEFER_BIT) || in_active_mode));
    end
  end

  assign system_en = system_en_q;
  assign interrupt_out_n = irq_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up selection.

  logic [4:0] ldo_auto; // LDO autostart bits, order 3, 7, 8, 9, 11.
  logic [7:0] rail_start_q; // Switch and buck start enables.
  logic [4:0] ldo_start_q; // LDO start enables.
  assign ldo_auto = {ldo_bypass_and_startup_q[`PMRB_LDO11_AUTO_BIT],
                     ldo_bypass_and_startup_q[`PMRB_LDO9_AUTO_BIT],
                     ldo_startup_select_q[`PMRB_LDO8_AUTO_BIT],
                     ldo_startup_select_q[`PMRB_LDO7_AUTO_BIT],
                     ldo_startup_select_q[`PMRB_LDO3_AUTO_BIT]};

  // During power-up a set bit forces the rail on, else its own setting applies.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_start_q <= '0;
      ldo_start_q <= '0;
    end else if (powering_up) begin
      rail_start_q <= buck_switch_startup_select_q | rail_own_conf;
      ldo_start_q <= ldo_auto | ldo_own_conf;
    end else begin
      rail_start_q <= '0;
      ldo_start_q <= '0;
    end
  end

  assign rail_start_en = rail_start_q;
  assign ldo_start_en = ldo_start_q;
  // One selects bypass, zero regulator mode.
  assign ldo_bypass = {ldo_bypass_and_startup_q[`PMRB_LDO_ELEVEN_BYPASS_BIT],
                       ldo_bypass_and_startup_q[`PMRB_LDO8_BYP_BIT],
                       ldo_bypass_and_startup_q[`PMRB_LDO7_BYP_BIT],
                       ldo_bypass_and_startup_q[`PMRB_LDO3_BYP_BIT]};
  assign ldo_eight_function = mem_io_buck_join_and_drive_q[`PMRB_LDO8_FUNC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Buck merging and drive.

  logic [7:0] io_eff_q; // IO buck controls after gating.
  logic [7:0] core2_eff_q; // Core buck two controls after gating.

  // Merged partners' own registers are ignored; the buck then follows its master.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_eff_q <= '0;
      core2_eff_q <= '0;
    end else begin
      io_eff_q <= mem_io_buck_join_and_drive_q[`PMRB_JOIN_BIT] ? '0 : io_buck_ctrl;
      core2_eff_q <= dual_phase ? '0 : core_buck_two_ctrl;
    end
  end

  assign io_buck_ctrl_eff = io_eff_q;
  assign core_buck_two_ctrl_eff = core2_eff_q;
  assign mem_io_buck_join = mem_io_buck_join_and_drive_q[`PMRB_JOIN_BIT];
  assign core_buck_dual_phase = dual_phase;
  // Full-current mode doubles pass device and current limit.
  assign core_buck_one_full_current = mem_io_buck_join_and_drive_q[`PMRB_CORE1_FULL_BIT];
  assign core_buck_two_full_current = mem_io_buck_join_and_drive_q[`PMRB_CORE2_FULL_BIT];
  assign processor_buck_full_current = mem_io_buck_join_and_drive_q[`PMRB_PROC_FULL_BIT];
  assign sense_on_feedback_two = fb2_is_sense;
  assign sense_on_core_switch_pin = dual_phase && remote_sense_en && route_to_pin;

  ////////////////////////////////////////////////////////////////////////////
  // PWM clock for the vibration driver.

  logic [5:0] div_q; // Clock divider.
  logic [5:0] step_q; // Step within one repetition period.
  logic slow_q; // Rate seen last cycle, to restart on a change.
  logic tick_q; // PWM clock tick.
  logic period_q; // Repetition period tick.

  // A rate change restarts the divider so no short period appears.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      step_q <= '0;
      slow_q <= 1'b0;
      tick_q <= 1'b0;
      period_q <= 1'b0;
    end else begin
      slow_q <= pwm_slow;
      tick_q <= 1'b0;
      period_q <= 1'b0;
      if (slow_q != pwm_slow) begin
        div_q <= '0;
        step_q <= '0;
      end else if (div_q == (pwm_slow ? DIV_SLOW_M1 : DIV_FAST_M1)) begin
        div_q <= '0;
        tick_q <= 1'b1;
        step_q <= step_q + 6'h01;
        period_q <= step_q == STEP_LAST;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  assign pwm_clk_tick = tick_q;
  assign pwm_period_tick = period_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence write_then_read_s;
    (reg_wr && reg_addr == `PMRB_ADDR_MERGE) ##1 !reg_wr
    ##1 (reg_rd && !reg_wr && reg_addr == `PMRB_ADDR_MERGE);
  endsequence

  readback_a: assert property (write_then_read_s |=> reg_rdata == $past(reg_wdata, 3))
    else $error("register readback differs from written value");
  force_reset_a: assert property (pin_opt_bit(`PMRB_FORCE_RST_BIT) |=> !system_reset_out_n)
    else $error("reset pin not asserted while forced");
  fb3_polarity_a: assert property (!pin_opt_bit(`PMRB_FB3_POL_BIT) && fb3_level
    |=> !feedback_output_three)
    else $error("feedback three not active low");
  fb2_open_drain_a: assert property (fb2_pol && fb2_is_power_good && !fb2_is_sense && fb2_level
    |=> !feedback_output_two_oe)
    else $error("feedback two drives while power is good");
  irq_defer_a: assert property (pin_opt_bit(`PMRB_IRQ_DEFER_BIT) && !in_active_mode
    |=> interrupt_out_n)
    else $error("interrupt asserted before active mode");
  sysen_keep_a: assert property (otp_second_read && !otp_first_read
    && pin_opt_bit(`PMRB_SYSEN_KEEP_BIT) |=> $stable(system_en))
    else $error("system enable changed while held");
  autostart_a: assert property (powering_up && buck_switch_startup_select_q[7]
    |=> rail_start_en[7])
    else $error("autostart rail not enabled");
  ldo_autostart_a: assert property (powering_up && ldo_startup_select_q[`PMRB_LDO8_AUTO_BIT]
    |=> ldo_start_en[2])
    else $error("LDO eight autostart not enabled");
  io_join_a: assert property (mem_io_buck_join |=> io_buck_ctrl_eff == 8'h00)
    else $error("IO buck controls pass while joined");
  dual_phase_a: assert property (dual_phase |=> core_buck_two_ctrl_eff == 8'h00)
    else $error("core buck two controls pass while merged");
  sense_route_a: assert property (dual_phase && remote_sense_en && !route_to_pin
    |-> sense_on_feedback_two ##1 !feedback_output_two_oe)
    else $error("feedback two still driven while sensing");
  pwm_fast_a: assert property (pwm_clk_tick && !pwm_slow && !slow_q
    ##1 (!pwm_slow)[*8] ##1 !pwm_slow |=> pwm_clk_tick)
    else $error("2 MHz PWM tick spacing wrong");
endmodule : pmrb_config_bank

`default_nettype wire

// [src/pmrb_params.svh]
// Address map, field positions, reset values and timing figures for the configuration bank.
`ifndef PMRB_PARAMS_SVH
`define PMRB_PARAMS_SVH

// Register addresses on the nine-bit register port.
`define PMRB_ADDR_PIN_OPT 9'h109
`define PMRB_ADDR_BUCK_START 9'h10A
`define PMRB_ADDR_LDO_BYP 9'h10B
`define PMRB_ADDR_LDO_START 9'h10C
`define PMRB_ADDR_MERGE 9'h10D

// Reset value of every register in the bank.
`define PMRB_REG_RESET 8'h00

// Fields of pin_and_interface_options.
`define PMRB_FB3_POL_BIT 7
`define PMRB_FB2_POL_BIT 6
`define PMRB_FORCE_RST_BIT 5
`define PMRB_HSM_BIT 4
`define PMRB_FMP_BIT 3
`define PMRB_SYSEN_KEEP_BIT 2
`define PMRB_IRQ_DEFER_BIT 1
`define PMRB_SUPPLY_BIT 0

// Fields of ldo_bypass_and_startup.
`define PMRB_LDO_ELEVEN_BYPASS_BIT 7
`define PMRB_LDO8_BYP_BIT 6
`define PMRB_LDO7_BYP_BIT 5
`define PMRB_LDO3_BYP_BIT 3
`define PMRB_LDO11_AUTO_BIT 2
`define PMRB_LDO9_AUTO_BIT 0

// Fields of ldo_startup_select.
`define PMRB_LDO8_AUTO_BIT 7
`define PMRB_LDO7_AUTO_BIT 6
`define PMRB_LDO3_AUTO_BIT 2

// Fields of mem_io_buck_join_and_drive.
`define PMRB_JOIN_BIT 7
`define PMRB_CORE1_FULL_BIT 6
`define PMRB_CORE2_FULL_BIT 5
`define PMRB_DUAL_PHASE_BIT 4
`define PMRB_PROC_FULL_BIT 3
`define PMRB_SENSE_ROUTE_BIT 2
`define PMRB_LDO8_FUNC_BIT 1
`define PMRB_PWM_CLK_BIT 0

// Timing figures: clock rates in hertz and PWM steps per repetition period.
`define PMRB_CLK_HZ 20000000
`define PMRB_PWM_FAST_HZ 2000000
`define PMRB_PWM_SLOW_HZ 1000000
`define PMRB_PWM_STEPS 64

`endif

// [src/pmrb_pkg.sv]
// Types shared by the configuration bank and its users.
`default_nettype none
package pmrb_pkg;
  // One configuration register.
  typedef logic [7:0] pmrb_byte_t;
  // Register port address.
  typedef logic [8:0] pmrb_addr_t;
  // PWM clock choice.
  typedef enum logic {PMRB_PWM_2MHZ = 1'b0, PMRB_PWM_1MHZ = 1'b1} pmrb_pwm_rate_t;
endpackage : pmrb_pkg
`default_nettype wire

// [verif/pmrb_host_model.sv]
// Host processor model that drives the register port of the configuration bank.
`timescale 1ns/1ps
`default_nettype none

module pmrb_host_model (
  // Clock.
  input wire logic clk,
  // Register port towards the bank.
  output pmrb_pkg::pmrb_addr_t reg_addr,
  output logic reg_wr,
  output pmrb_pkg::pmrb_byte_t reg_wdata,
  output logic reg_rd,
  input wire pmrb_pkg::pmrb_byte_t reg_rdata
);
  import pmrb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // The port idles with both strobes low.
  initial begin
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write strobe; the page 2/3 address pair is already resolved here.
  // This host writes every data byte as given, feedback codes included.
  task automatic wr(input pmrb_addr_t addr, input pmrb_byte_t data);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released lines carry no stale value, so a late sample shows up.
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : wr

  // One read strobe; the data is taken half a cycle after the strobe edge.
  task automatic rd(input pmrb_addr_t addr, output pmrb_byte_t data);
    @(negedge clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk);
    data = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~addr;
  endtask : rd
endmodule : pmrb_host_model

`default_nettype wire

// [verif/pmrb_config_bank_test.sv]
// Self-checking testbench of the configuration bank.
`timescale 1ns/1ps
`default_nettype none
`include "pmrb_params.svh"

module pmrb_config_bank_test;
  import pmrb_pkg::*;

  // Row of the register table: write, expected read-back, expected direct outputs.
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
    logic [7:0] rdback;
    logic [12:0] vec;
  } pmrb_row_t;

  localparam int CLK_HZ = 20000000;
  localparam int FAST_DIV = CLK_HZ / `PMRB_PWM_FAST_HZ;
  localparam int SLOW_DIV = CLK_HZ / `PMRB_PWM_SLOW_HZ;

  // Unmapped writes must leave everything alone and read back as zero.
  localparam pmrb_row_t ROWS [10] = '{
    '{9'h109, 8'h19, 8'h19, 13'h0007}, '{9'h10B, 8'hFF, 8'hFF, 13'h007F},
    '{9'h10C, 8'h38, 8'h38, 13'h007F}, '{9'h10D, 8'hFA, 8'hFA, 13'h1FFF},
    '{9'h10A, 8'h5A, 8'h5A, 13'h1FFF}, '{9'h10B, 8'h00, 8'h00, 13'h1F87},
    '{9'h10D, 8'h00, 8'h00, 13'h0007}, '{9'h109, 8'h00, 8'h00, 13'h0000},
    '{9'h108, 8'hFF, 8'h00, 13'h0000}, '{9'h10E, 8'hA5, 8'h00, 13'h0000}};

  logic clk, rst_n, fb3_level, fb2_level, fb2_is_power_good, reset_request;
  logic otp_first_read, otp_second_read, otp_system_en, event_pending, in_active_mode;
  logic powering_up, remote_sense_en;
  logic [7:0] rail_own_conf, io_buck_ctrl, core_buck_two_ctrl;
  logic [4:0] ldo_own_conf;
  wire pmrb_addr_t reg_addr;
  wire pmrb_byte_t reg_wdata, reg_rdata, io_eff, core2_eff;
  wire logic reg_wr, reg_rd, fb3_out, fb2_o, fb2_oe, rst_out_n, hsm, fmp, supply, sys_en;
  wire logic irq_n, ldo8_f, join_b, dual, c1_full, c2_full, proc_full, sense_fb2, sense_pin;
  wire logic clk_tick, period_tick;
  wire logic [7:0] rail_en;
  wire logic [4:0] ldo_en;
  wire logic [3:0] ldo_byp;
  wire logic [12:0] obs_vec;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  int k;
  pmrb_byte_t rdv;

  // Direct register outputs gathered in row order.
  assign obs_vec = {join_b, dual, c1_full, c2_full, proc_full, ldo8_f, ldo_byp, hsm, fmp, supply};

  ////////////////////////////////////////////////////////////////////////////////
  pmrb_host_model pmrb_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  pmrb_config_bank #(.CLK_HZ(CLK_HZ)) pmrb_config_bank_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fb3_level(fb3_level), .fb2_level(fb2_level),
    .fb2_is_power_good(fb2_is_power_good), .reset_request(reset_request),
    .feedback_output_three(fb3_out), .feedback_output_two_o(fb2_o),
    .feedback_output_two_oe(fb2_oe), .system_reset_out_n(rst_out_n),
    .continuous_highspeed_select(hsm), .fast_plus_timing_select(fmp),
    .input_supply_select(supply), .otp_first_read(otp_first_read),
    .otp_second_read(otp_second_read), .otp_system_en(otp_system_en), .system_en(sys_en),
    .event_pending(event_pending), .in_active_mode(in_active_mode), .interrupt_out_n(irq_n),
    .powering_up(powering_up), .rail_own_conf(rail_own_conf), .ldo_own_conf(ldo_own_conf),
    .rail_start_en(rail_en), .ldo_start_en(ldo_en), .ldo_bypass(ldo_byp),
    .ldo_eight_function(ldo8_f), .io_buck_ctrl(io_buck_ctrl),
    .core_buck_two_ctrl(core_buck_two_ctrl), .remote_sense_en(remote_sense_en),
    .io_buck_ctrl_eff(io_eff), .core_buck_two_ctrl_eff(core2_eff), .mem_io_buck_join(join_b),
    .core_buck_dual_phase(dual), .core_buck_one_full_current(c1_full),
    .core_buck_two_full_current(c2_full), .processor_buck_full_current(proc_full),
    .sense_on_feedback_two(sense_fb2), .sense_on_core_switch_pin(sense_pin),
    .pwm_clk_tick(clk_tick), .pwm_period_tick(period_tick));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Registered outputs need the write edge plus one more edge.
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle

  // One-cycle pulse of an OTP read carrying the given OTP value.
  task automatic otp_pulse(input bit second, input logic val);
    @(negedge clk);
    otp_system_en = val;
    if (second) otp_second_read = 1'b1; else otp_first_read = 1'b1;
    @(negedge clk);
    otp_first_read = 1'b0;
    otp_second_read = 1'b0;
    otp_system_en = ~val;
    @(negedge clk);
  endtask : otp_pulse

  // Counts cycles to the next tick; a missing tick ends the run.
  task automatic wait_tick(input bit period, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (((period ? period_tick : clk_tick) !== 1'b1) && cnt < 3000);
    if (cnt >= 3000) begin
      n_mismatch++;
      $display("[ERR] %0t tick wait ran out", $time);
      complete_run;
    end
  endtask : wait_tick

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard.
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end

  initial begin
    {rst_n, fb3_level, fb2_level, fb2_is_power_good, reset_request, otp_first_read} = '0;
    {otp_second_read, otp_system_en, event_pending, in_active_mode, powering_up} = '0;
    remote_sense_en = 1'b0;
    rail_own_conf = 8'h0F;
    ldo_own_conf = 5'b00010;
    io_buck_ctrl = 8'h3C;
    core_buck_two_ctrl = 8'hC3;
    repeat (20) @(negedge clk);
    check(rst_out_n, 1'b0, "reset pin during reset");
    rst_n = 1'b1;
    settle();
    check(rst_out_n, 1'b1, "reset pin after reset");
    for (int a = 9; a <= 13; a++) begin
      pmrb_host_model_inst.rd(9'h100 + 9'(a), rdv);
      check(rdv, `PMRB_REG_RESET, "reset value");
    end
    // Register table rows: write, read back, direct outputs.
    foreach (ROWS[i]) begin
      pmrb_host_model_inst.wr(ROWS[i].addr, ROWS[i].data);
      pmrb_host_model_inst.rd(ROWS[i].addr, rdv);
      check(rdv, ROWS[i].rdback, "read back");
      check(obs_vec, ROWS[i].vec, "direct outputs");
    end
    // Feedback pin polarity and drive type.
    {fb3_level, fb2_level, fb2_is_power_good} = 3'b111;
    settle();
    check(fb3_out, 1'b0, "fb3 active low");
    check({fb2_oe, fb2_o}, 2'b10, "fb2 push-pull low");
    pmrb_host_model_inst.wr(9'h109, 8'hC0);
    settle();
    check(fb3_out, 1'b1, "fb3 active high");
    check(fb2_oe, 1'b0, "fb2 open drain released");
    fb2_level = 1'b0;
    settle();
    check({fb2_oe, fb2_o}, 2'b10, "fb2 open drain low");
    // Forced reset follows the bit both ways.
    pmrb_host_model_inst.wr(9'h109, 8'h20);
    settle();
    check(rst_out_n, 1'b0, "forced reset");
    pmrb_host_model_inst.wr(9'h109, 8'h00);
    settle();
    check(rst_out_n, 1'b1, "forced reset off");
    // System-enable reload on the second OTP read.
    otp_pulse(1'b0, 1'b1);
    otp_pulse(1'b1, 1'b0);
    check(sys_en, 1'b0, "second read reloads");
    pmrb_host_model_inst.wr(9'h109, 8'h04);
    otp_pulse(1'b0, 1'b1);
    otp_pulse(1'b1, 1'b0);
    check(sys_en, 1'b1, "second read keeps");
    // Interrupt deferral below active mode.
    event_pending = 1'b1;
    pmrb_host_model_inst.wr(9'h109, 8'h00);
    settle();
    check(irq_n, 1'b0, "irq immediate");
    pmrb_host_model_inst.wr(9'h109, 8'h02);
    settle();
    check(irq_n, 1'b1, "irq deferred");
    in_active_mode = 1'b1;
    settle();
    check(irq_n, 1'b0, "irq after active");
    event_pending = 1'b0;
    // Start-up selection during power-up.
    powering_up = 1'b1;
    pmrb_host_model_inst.wr(9'h10A, 8'hA0);
    pmrb_host_model_inst.wr(9'h10B, 8'h01);
    pmrb_host_model_inst.wr(9'h10C, 8'h84);
    settle();
    check(rail_en, 8'hAF, "rail start");
    check(ldo_en, 5'b01111, "ldo start");
    powering_up = 1'b0;
    // Buck merging and sense routing.
    pmrb_host_model_inst.wr(9'h10D, 8'h80);
    settle();
    check({io_eff, core2_eff}, 16'h00C3, "join ignores io buck");
    remote_sense_en = 1'b1;
    pmrb_host_model_inst.wr(9'h10D, 8'h14);
    settle();
    check({io_eff, core2_eff}, 16'h3C00, "dual ignores core two");
    check({sense_fb2, sense_pin}, 2'b01, "sense on pin");
    pmrb_host_model_inst.wr(9'h10D, 8'h10);
    settle();
    check({sense_fb2, sense_pin, fb2_oe}, 3'b100, "sense on fb2");
    remote_sense_en = 1'b0;
    // PWM clock rate and repetition period.
    pmrb_host_model_inst.wr(9'h10D, 8'h00);
    wait_tick(1'b0, n);
    wait_tick(1'b0, n);
    check(16'(n), 16'(FAST_DIV), "fast tick spacing");
    pmrb_host_model_inst.wr(9'h10D, 8'h01);
    wait_tick(1'b0, n);
    wait_tick(1'b0, n);
    check(16'(n), 16'(SLOW_DIV), "slow tick spacing");
    wait_tick(1'b1, n);
    k = 0;
    do begin
      wait_tick(1'b0, n);
      k++;
    end while (period_tick !== 1'b1 && k < 100);
    check(16'(k), 16'(`PMRB_PWM_STEPS), "ticks per period");
    complete_run;
  end
endmodule : pmrb_config_bank_test

`default_nettype wire
